// ==== design/scm_top.sv ====
// system control block: register slave, routing and sideband outputs
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "scm_cfg.svh"
module scm_top #(
  parameter int ADDR_W = 8,
  parameter int NCPU = 2,
  parameter int ECC_N = 8,
  parameter int PAR_N = 4,
  parameter int IRQ_N = 8,
  parameter int STAT_W = 32,
  parameter logic [7:0] CORE_COUNT = 8'h02,
  parameter logic CAN_PRESENT = 1'h1
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire scm_pkg::scm_word_t s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output scm_pkg::scm_resp_t s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output scm_pkg::scm_word_t s_axi_rdata_o,
  output scm_pkg::scm_resp_t s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [7:0] fab_dma_req_i,
  input wire logic [1:0] can0_dma_req_i,
  input wire logic [1:0] can1_dma_req_i,
  output logic [7:0] dma_req_o,
  output logic dma_mgr_nonsecure_o,
  output logic dma_irq_nonsecure_o,
  output scm_pkg::scm_word_t dma_periph_nonsecure_o,
  input wire logic pin_tck_i,
  input wire logic pin_tms_i,
  input wire logic pin_tdi_i,
  input wire logic scan_tck_i,
  input wire logic scan_tms_i,
  input wire logic scan_tdi_i,
  input wire logic fab_tdo_i,
  output logic fab_tck_o,
  output logic fab_tms_o,
  output logic fab_tdi_o,
  output logic pin_tdo_o,
  output logic scan_tdo_o,
  input wire logic [NCPU-1:0] cpu_debug_i,
  output logic [NCPU-1:0] wd_pause_o,
  input wire logic serial_cfg_i,
  output logic io_freeze_o,
  input wire logic [2:0] boot_source_pins_i,
  input wire logic [1:0] clock_source_pins_i,
  output logic [ECC_N-1:0] ecc_en_o,
  output logic [ECC_N-1:0] ecc_inject_o,
  output logic [PAR_N-1:0] parity_inject_o,
  input wire logic [IRQ_N-1:0] ecc_irq_i,
  output logic [IRQ_N-1:0] mpu_ecc_irq_o,
  input wire logic [STAT_W-1:0] mod_status_i
);
  import scm_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // total width of all outside levels
  localparam int SW = 12 + 7 + NCPU + 1 + 5 + IRQ_N + STAT_W;
  // synchronised view of every outside level
  logic [SW-1:0] sync_vec;
  logic [7:0] fab_s;
  logic [1:0] can0_s;
  logic [1:0] can1_s;
  logic [6:0] jtag_s;
  logic [NCPU-1:0] dbg_s;
  logic cfg_s;
  logic [4:0] pins_s;
  logic [IRQ_N-1:0] irq_s;
  logic [STAT_W-1:0] stat_s;

  scm_sync #(.W(SW)) u_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .async_i({fab_dma_req_i, can0_dma_req_i, can1_dma_req_i,
              pin_tck_i, pin_tms_i, pin_tdi_i,
              scan_tck_i, scan_tms_i, scan_tdi_i, fab_tdo_i,
              cpu_debug_i, serial_cfg_i,
              boot_source_pins_i, clock_source_pins_i,
              ecc_irq_i, mod_status_i}),
    .sync_o(sync_vec)
  );

  // split the synchronised vector back into its groups
  assign {fab_s, can0_s, can1_s, jtag_s, dbg_s, cfg_s, pins_s, irq_s,
          stat_s} = sync_vec;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // byte-lane merge of a write into an old word
  function automatic scm_word_t scm_merge(input scm_word_t old_w,
                                          input scm_word_t new_w,
                                          input logic [3:0] strb);
    scm_word_t res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : scm_merge

  // true when an address names a mapped register
  function automatic logic scm_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] a8;
    a8 = 8'(a);
    return (a8 <= `SCM_OFS_MOD_STAT) && (a8[1:0] == 2'h0);
  endfunction : scm_mapped

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic jtag_sel_ff; // 1: scan controller drives fabric jtag
  logic [`SCM_ROUTE_W-1:0] route_ff; // per-line can select
  logic [1:0] dma_sec_ff; // manager and irq nonsecure
  scm_word_t persec_ff; // per-request nonsecure bits
  logic [NCPU-1:0] wd_en_ff; // pause enable per watchdog
  logic freeze_ff; // software freeze hold
  logic [4:0] boot_ff; // captured boot and clock pins
  logic [1:0] samp_cnt_ff; // wait for synchronised pins
  logic samp_done_ff; // pins captured once
  scm_word_t scratch_ff [`SCM_SCRATCH_N]; // boot-stage scratch
  logic [ECC_N-1:0] ecc_en_ff;
  logic [ECC_N-1:0] ecc_inj_ff;
  logic [PAR_N-1:0] par_inj_ff;
  logic [IRQ_N-1:0] irq_ff; // routed interrupt levels
  logic [STAT_W-1:0] stat_ff; // captured module status

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  scm_wr_st_t wr_st_ff;
  scm_wr_st_t nxt_wr_st;
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] waddr_ff;
  scm_word_t wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  scm_resp_t bresp_ff;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic [7:0] wa8;

  assign aw_take = s_axi_awvalid_i && awready_ff;
  assign w_take = s_axi_wvalid_i && wready_ff;
  assign do_write = (wr_st_ff == SCM_WR_WRITE);
  assign wa8 = 8'(waddr_ff);

  // next write state from the captures and the response handshake
  always_comb begin
    nxt_wr_st = wr_st_ff;
    case (wr_st_ff)
      SCM_WR_IDLE, SCM_WR_COLLECT: begin
        if ((aw_got_ff || aw_take) && (w_got_ff || w_take)) begin
          nxt_wr_st = SCM_WR_WRITE;
        end else if (aw_take || w_take) begin
          nxt_wr_st = SCM_WR_COLLECT;
        end
      end
      SCM_WR_WRITE: nxt_wr_st = SCM_WR_RESP;
      SCM_WR_RESP: begin
        if (s_axi_bready_i) begin
          nxt_wr_st = SCM_WR_IDLE;
        end
      end
      default: nxt_wr_st = SCM_WR_IDLE;
    endcase
  end

  // address and data captured in either order, released after response
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_st_ff <= SCM_WR_IDLE;
      aw_got_ff <= 1'h0;
      w_got_ff <= 1'h0;
      awready_ff <= 1'h0;
      wready_ff <= 1'h0;
      bvalid_ff <= 1'h0;
      bresp_ff <= `SCM_RESP_OKAY;
      waddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= 4'h0;
    end else if (ce_i) begin
      wr_st_ff <= nxt_wr_st;
      if (aw_take) begin
        waddr_ff <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      aw_got_ff <= (aw_got_ff || aw_take) && !do_write;
      w_got_ff <= (w_got_ff || w_take) && !do_write;
      awready_ff <= (nxt_wr_st == SCM_WR_IDLE) ||
                    ((nxt_wr_st == SCM_WR_COLLECT) && !aw_got_ff &&
                     !aw_take);
      wready_ff <= (nxt_wr_st == SCM_WR_IDLE) ||
                   ((nxt_wr_st == SCM_WR_COLLECT) && !w_got_ff &&
                    !w_take);
      bvalid_ff <= (nxt_wr_st == SCM_WR_RESP);
      if (do_write) begin
        bresp_ff <= scm_mapped(waddr_ff) ? `SCM_RESP_OKAY :
                    `SCM_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers written by software
  // ----------------------------------------------------------------
  // jtag select, route field and dma security
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      jtag_sel_ff <= 1'h0;
      route_ff <= `SCM_ROUTE_RST;
      dma_sec_ff <= 2'h0;
      persec_ff <= '0;
    end else if (ce_i && do_write) begin
      case (wa8)
        `SCM_OFS_JTAG_CTRL: if (wstrb_ff[0]) begin
          jtag_sel_ff <= wdata_ff[0];
        end
        `SCM_OFS_DMA_ROUTE: if (wstrb_ff[0]) begin
          route_ff <= wdata_ff[`SCM_ROUTE_W-1:0];
        end
        `SCM_OFS_DMA_SEC: if (wstrb_ff[0]) begin
          dma_sec_ff <= wdata_ff[1:0];
        end
        `SCM_OFS_DMA_PERSEC: begin
          persec_ff <= scm_merge(persec_ff, wdata_ff, wstrb_ff);
        end
        default: ;
      endcase
    end
  end

  // watchdog enables, freeze hold, ecc and parity controls
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wd_en_ff <= '1;
      freeze_ff <= `SCM_FREEZE_RST;
      ecc_en_ff <= '0;
      ecc_inj_ff <= '0;
      par_inj_ff <= '0;
    end else if (ce_i && do_write) begin
      case (wa8)
        `SCM_OFS_WD_PAUSE: if (wstrb_ff[0]) begin
          wd_en_ff <= wdata_ff[NCPU-1:0];
        end
        `SCM_OFS_FREEZE: if (wstrb_ff[0]) begin
          freeze_ff <= wdata_ff[`SCM_FREEZE_BIT];
        end
        `SCM_OFS_ECC_EN: begin
          ecc_en_ff <= ECC_N'(scm_merge(32'(ecc_en_ff), wdata_ff,
                                        wstrb_ff));
        end
        `SCM_OFS_ECC_INJ: begin
          ecc_inj_ff <= ECC_N'(scm_merge(32'(ecc_inj_ff), wdata_ff,
                                         wstrb_ff));
        end
        `SCM_OFS_PAR_INJ: begin
          par_inj_ff <= PAR_N'(scm_merge(32'(par_inj_ff), wdata_ff,
                                         wstrb_ff));
        end
        default: ;
      endcase
    end
  end

  // eight scratch words for boot-stage hand-off
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `SCM_SCRATCH_N; i++) begin
        scratch_ff[i] <= '0;
      end
    end else if (ce_i && do_write) begin
      for (int i = 0; i < `SCM_SCRATCH_N; i++) begin
        if (wa8 == `SCM_OFS_SCRATCH0 + 8'(4 * i)) begin
          scratch_ff[i] <= scm_merge(scratch_ff[i], wdata_ff,
                                     wstrb_ff);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status capture
  // ----------------------------------------------------------------
  // boot and clock pins caught once, after the synchroniser fills
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      samp_cnt_ff <= 2'h0;
      samp_done_ff <= 1'h0;
      boot_ff <= 5'h00;
    end else if (ce_i && !samp_done_ff) begin
      samp_cnt_ff <= samp_cnt_ff + 2'h1;
      if (samp_cnt_ff == `SCM_SAMPLE_WAIT) begin
        boot_ff <= pins_s;
        samp_done_ff <= 1'h1;
      end
    end
  end

  // module status and interrupt levels, refreshed every cycle that ce_i is high
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      stat_ff <= '0;
      irq_ff <= '0;
    end else if (ce_i) begin
      stat_ff <= stat_s;
      irq_ff <= irq_s;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic arready_ff;
  logic rvalid_ff;
  scm_word_t rdata_ff;
  scm_resp_t rresp_ff;
  scm_word_t rd_word;
  logic ar_take;
  logic [7:0] ra8;

  assign ar_take = s_axi_arvalid_i && arready_ff;
  assign ra8 = 8'(s_axi_araddr_i);

  // read mux; reads have no side effects
  always_comb begin
    rd_word = '0;
    case (ra8)
      `SCM_OFS_JTAG_CTRL: rd_word[0] = jtag_sel_ff;
      `SCM_OFS_DMA_ROUTE: rd_word[`SCM_ROUTE_W-1:0] = route_ff;
      `SCM_OFS_DMA_SEC: rd_word[1:0] = dma_sec_ff;
      `SCM_OFS_DMA_PERSEC: rd_word = persec_ff;
      `SCM_OFS_WD_PAUSE: rd_word[NCPU-1:0] = wd_en_ff;
      `SCM_OFS_FREEZE: rd_word[0] = io_freeze_o;
      `SCM_OFS_BOOT_INFO: begin
        rd_word[2:0] = boot_ff[4:2];
        rd_word[`SCM_BOOT_CLK_POS +: 2] = boot_ff[1:0];
      end
      `SCM_OFS_VARIANT: begin
        rd_word[7:0] = CORE_COUNT;
        rd_word[`SCM_VAR_CAN_POS] = CAN_PRESENT;
      end
      `SCM_OFS_ECC_EN: rd_word[ECC_N-1:0] = ecc_en_ff;
      `SCM_OFS_ECC_INJ: rd_word[ECC_N-1:0] = ecc_inj_ff;
      `SCM_OFS_PAR_INJ: rd_word[PAR_N-1:0] = par_inj_ff;
      `SCM_OFS_IRQ_STAT: rd_word[IRQ_N-1:0] = irq_ff;
      `SCM_OFS_MOD_STAT: rd_word[STAT_W-1:0] = stat_ff;
      default: begin
        // unaligned scratch addresses answer with zero data
        if (ra8 >= `SCM_OFS_SCRATCH0 && ra8 < `SCM_OFS_ECC_EN &&
            ra8[1:0] == 2'h0) begin
          rd_word = scratch_ff[ra8[4:2]];
        end
      end
    endcase
  end

  // one read at a time, answer one edge after the address is taken
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      arready_ff <= 1'h0;
      rvalid_ff <= 1'h0;
      rdata_ff <= '0;
      rresp_ff <= `SCM_RESP_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        rdata_ff <= rd_word;
        rresp_ff <= scm_mapped(s_axi_araddr_i) ? `SCM_RESP_OKAY :
                    `SCM_RESP_SLVERR;
      end
      rvalid_ff <= ar_take || (rvalid_ff && !s_axi_rready_i);
      arready_ff <= !(ar_take || (rvalid_ff && !s_axi_rready_i));
    end
  end

  // ----------------------------------------------------------------
  // sideband outputs
  // ----------------------------------------------------------------
  logic [7:0] dma_ff;
  logic [2:0] fjtag_ff;
  logic [1:0] tdo_ff;
  logic [NCPU-1:0] pause_ff;
  logic frz_out_ff;

  // request routing; lines 0-3 fixed, 4-7 by route bits
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dma_ff <= 8'h00;
    end else if (ce_i) begin
      dma_ff[3:0] <= fab_s[3:0];
      dma_ff[4] <= route_ff[0] ? can0_s[0] : fab_s[4];
      dma_ff[5] <= route_ff[1] ? can0_s[1] : fab_s[5];
      dma_ff[6] <= route_ff[2] ? can1_s[0] : fab_s[6];
      dma_ff[7] <= route_ff[3] ? can1_s[1] : fab_s[7];
    end
  end

  // fabric jtag mux; tdo returned only to the selected source
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      fjtag_ff <= 3'h0;
      tdo_ff <= 2'h0;
    end else if (ce_i) begin
      fjtag_ff <= jtag_sel_ff ? jtag_s[3:1] : jtag_s[6:4];
      tdo_ff <= jtag_sel_ff ? {1'h0, jtag_s[0]} : {jtag_s[0], 1'h0};
    end
  end

  // watchdog pause and i/o freeze
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pause_ff <= '0;
      frz_out_ff <= 1'h1;
    end else if (ce_i) begin
      pause_ff <= dbg_s & wd_en_ff;
      frz_out_ff <= freeze_ff || cfg_s;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fixed_lines: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i |=> dma_req_o[3:0] == $past(fab_s[3:0]))
    else $error("request lines 0-3 not from fabric");
  a_route_low: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i |=> dma_req_o[4] == $past(route_ff[0] ? can0_s[0] : fab_s[4]))
    else $error("request line 4 misrouted");
  a_route_high: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && route_ff[3] |=> dma_req_o[7] == $past(can1_s[1]))
    else $error("request line 7 not from second can");
  a_route_reset: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $past(sys_rst_i) |-> route_ff == 4'h0)
    else $error("route field not zero after reset");
  a_jtag_source: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i |=> fab_tck_o == $past(jtag_sel_ff ? jtag_s[3] : jtag_s[6]))
    else $error("fabric jtag clock from wrong source");
  a_wd_pause: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i |=> wd_pause_o == $past(dbg_s & wd_en_ff))
    else $error("watchdog pause mismatch");
  a_freeze_cfg: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && cfg_s |=> io_freeze_o)
    else $error("pins not frozen during configuration");
  a_freeze_reset: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $past(sys_rst_i) |-> io_freeze_o)
    else $error("pins not frozen after reset");
  a_write_answer: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && do_write |=> s_axi_bvalid_o && !s_axi_awready_o)
    else $error("write response missing");
  a_read_answer: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    ce_i && ar_take |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read response missing");

  // ----------------------------------------------------------------
  // output drive
  // ----------------------------------------------------------------
  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign dma_req_o = dma_ff;
  assign dma_mgr_nonsecure_o = dma_sec_ff[`SCM_SEC_MGR_BIT];
  assign dma_irq_nonsecure_o = dma_sec_ff[`SCM_SEC_IRQ_BIT];
  assign dma_periph_nonsecure_o = persec_ff;
  assign {fab_tck_o, fab_tms_o, fab_tdi_o} = fjtag_ff;
  assign {pin_tdo_o, scan_tdo_o} = tdo_ff;
  assign wd_pause_o = pause_ff;
  assign io_freeze_o = frz_out_ff;
  assign ecc_en_o = ecc_en_ff;
  assign ecc_inject_o = ecc_inj_ff;
  assign parity_inject_o = par_inj_ff;
  assign mpu_ecc_irq_o = irq_ff;
endmodule : scm_top

// ==== pkg/scm_cfg.svh ====
// offsets, field positions, reset values and counts of the system control block
`ifndef SCM_CFG_SVH
`define SCM_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SCM_OFS_JTAG_CTRL 8'h00
`define SCM_OFS_DMA_ROUTE 8'h04
`define SCM_OFS_DMA_SEC 8'h08
`define SCM_OFS_DMA_PERSEC 8'h0c
`define SCM_OFS_WD_PAUSE 8'h10
`define SCM_OFS_FREEZE 8'h14
`define SCM_OFS_BOOT_INFO 8'h18
`define SCM_OFS_VARIANT 8'h1c
`define SCM_OFS_SCRATCH0 8'h20
`define SCM_OFS_ECC_EN 8'h40
`define SCM_OFS_ECC_INJ 8'h44
`define SCM_OFS_PAR_INJ 8'h48
`define SCM_OFS_IRQ_STAT 8'h4c
`define SCM_OFS_MOD_STAT 8'h50

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SCM_ROUTE_W 4
`define SCM_ROUTE_RST 4'h0
`define SCM_FIXED_REQ 4
`define SCM_SEC_MGR_BIT 0
`define SCM_SEC_IRQ_BIT 1
`define SCM_FREEZE_BIT 0
`define SCM_FREEZE_RST 1'h1
`define SCM_BOOT_CLK_POS 8
`define SCM_VAR_CAN_POS 8
`define SCM_SCRATCH_N 8
`define SCM_SYNC_STAGES 2
`define SCM_SAMPLE_WAIT 2'h3
`define SCM_RESP_OKAY 2'h0
`define SCM_RESP_SLVERR 2'h2

`endif

// ==== pkg/scm_pkg.sv ====
// types shared by the system control block
package scm_pkg;
  // bus data word
  typedef logic [31:0] scm_word_t;
  // bus response code
  typedef logic [1:0] scm_resp_t;
  // write channel progress, gray along idle-collect-write-resp
  typedef enum logic [1:0] {
    SCM_WR_IDLE = 2'h0,
    SCM_WR_COLLECT = 2'h1,
    SCM_WR_WRITE = 2'h3,
    SCM_WR_RESP = 2'h2
  } scm_wr_st_t;
endpackage : scm_pkg

// ==== design/scm_sync.sv ====
// two-stage synchroniser for a vector of outside levels
`timescale 1ns/1ps
module scm_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  // first stage, read only by the second
  logic [W-1:0] meta_ff;
  // second stage
  logic [W-1:0] sync_ff;

  // both stages move together under the clock enable
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule : scm_sync

// ==== test/scm_peer_model.sv ====
// model of the request sources beside the control block
`timescale 1ns/1ps
module scm_peer_model (
  input wire logic flip_i,
  output logic [7:0] fab_req_o,
  output logic [1:0] can0_req_o,
  output logic [1:0] can1_req_o
);
  // fabric lines 4-7 always differ from the matching can lines
  assign fab_req_o = {{4{flip_i}}, 4'ha ^ {4{flip_i}}};
  assign can0_req_o = {2{~flip_i}};
  assign can1_req_o = {2{~flip_i}};
endmodule : scm_peer_model

// ==== test/tb_top.sv ====
// self-checking bench of the system control block
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i = 0, sys_rst_i = 1, ce_i = 1, flip = 0, serial_cfg_i = 0;
  logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, ecc_irq_i = 0;
  logic [7:0] fab_dma_req_i, dma_req_o, ecc_en_o, ecc_inject_o;
  logic [7:0] mpu_ecc_irq_o;
  logic [31:0] s_axi_wdata_i = 0, mod_status_i = 0, s_axi_rdata_o;
  logic [31:0] dma_periph_nonsecure_o;
  logic [3:0] s_axi_wstrb_i = 4'hf, parity_inject_o;
  logic [2:0] boot_source_pins_i = 3'h5;
  logic [1:0] clock_source_pins_i = 2'h2, cpu_debug_i = 0, wd_pause_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, can0_dma_req_i, can1_dma_req_i;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, fab_tdo_i = 1;
  logic pin_tck_i = 1, pin_tms_i = 1, pin_tdi_i = 1;
  logic scan_tck_i = 0, scan_tms_i = 0, scan_tdi_i = 0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, dma_mgr_nonsecure_o, dma_irq_nonsecure_o;
  logic fab_tck_o, fab_tms_o, fab_tdi_o, pin_tdo_o, scan_tdo_o, io_freeze_o;
  int failures = 0, checks_done = 0, cyc = 0;
  // fabric jtag outputs and both tdo returns as one word
  logic [4:0] jtag_v;
  assign jtag_v = {fab_tck_o, fab_tms_o, fab_tdi_o, pin_tdo_o,
                   scan_tdo_o};
  logic [31:0] d;
  logic [1:0] r;
  scm_top u_dut (.*);
  scm_peer_model u_peer (.flip_i(flip), .fab_req_o(fab_dma_req_i),
    .can0_req_o(can0_dma_req_i), .can1_req_o(can1_dma_req_i));
  always #20 sys_clk_i = ~sys_clk_i;
  // ------------------------------------------------------------
  // bus tasks and checks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end while (s_axi_bvalid_o !== 1'b1);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end while (s_axi_rvalid_o !== 1'b1);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 0;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(8'h04);
    chk(d, 0, "route reset");
    chk(dma_req_o, 8'h0a, "fixed lines");
    chk(io_freeze_o, 1, "freeze reset");
    rd(8'h1c);
    chk(d, 32'h102, "variant");
    $display("test reset done");
  endtask : t_reset
  task automatic t_route;
    logic [7:0] e;
    for (int i = 0; i < 16; i++) begin
      flip <= i[0];
      wr(8'h04, i);
      repeat (4) @(posedge sys_clk_i);
      e = {{4{i[0]}} ^ i[3:0], 4'ha ^ {4{i[0]}}};
      chk(dma_req_o, e, "route");
    end
    $display("test route done");
  endtask : t_route
  task automatic t_side;
    wr(8'h40, 32'h3c);
    wr(8'h44, 32'hc3);
    wr(8'h48, 32'h9);
    wr(8'h08, 32'h3);
    wr(8'h0c, 32'h1234_5678);
    repeat (2) @(posedge sys_clk_i);
    chk(ecc_en_o, 8'h3c, "ecc en");
    chk(ecc_inject_o, 8'hc3, "ecc inject");
    chk(parity_inject_o, 4'h9, "parity inject");
    chk({dma_mgr_nonsecure_o, dma_irq_nonsecure_o}, 2'h3, "sec");
    chk(dma_periph_nonsecure_o, 32'h1234_5678, "persec");
    chk(jtag_v, 5'h1e, "pin");
    wr(8'h00, 32'h1);
    repeat (4) @(posedge sys_clk_i);
    chk(jtag_v, 5'h01, "scan");
    $display("test side done");
  endtask : t_side
  task automatic t_regs;
    for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), 32'h5a00_0000 | i);
    for (int i = 0; i < 8; i++) begin
      rd(8'h20 + 8'(4 * i));
      chk(d, 32'h5a00_0000 | i, "scratch");
    end
    rd(8'h18);
    chk(d, 32'h205, "boot");
    rd(8'h54);
    chk(r, 2, "bad read resp");
    chk(d, 0, "bad read data");
    wr(8'h54, 32'h1);
    chk(r, 2, "bad write");
    $display("test regs done");
  endtask : t_regs
  task automatic t_stat;
    ecc_irq_i <= 8'h81;
    mod_status_i <= 32'hdead_beef;
    cpu_debug_i <= 2'h2;
    serial_cfg_i <= 1;
    wr(8'h14, 0);
    repeat (4) @(posedge sys_clk_i);
    chk(io_freeze_o, 1, "cfg freeze");
    chk(mpu_ecc_irq_o, 8'h81, "irq");
    chk(wd_pause_o, 2'h2, "pause");
    ce_i <= 0;
    ecc_irq_i <= 8'h18;
    repeat (4) @(posedge sys_clk_i);
    chk(mpu_ecc_irq_o, 8'h81, "irq held by ce");
    ce_i <= 1;
    serial_cfg_i <= 0;
    repeat (4) @(posedge sys_clk_i);
    chk(io_freeze_o, 0, "thaw");
    chk(mpu_ecc_irq_o, 8'h18, "irq after ce");
    rd(8'h50);
    chk(d, 32'hdead_beef, "status");
    $display("test stat done");
  endtask : t_stat
  // cycle ceiling against hangs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 0;
    repeat (2) @(posedge sys_clk_i);
    t_reset;
    t_route;
    t_side;
    t_regs;
    t_stat;
    complete_run;
  end
endmodule : tb_top
